/* rtl/std_timer_pkg.sv */
package std_timer_pkg;

    // Register bus shape
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [2:0] OFF_CTRL0   = 3'h0;
    localparam logic [2:0] OFF_CTRL1   = 3'h1;
    localparam logic [2:0] OFF_CNT_LO  = 3'h2;
    localparam logic [2:0] OFF_CNT_HI  = 3'h3;
    localparam logic [2:0] OFF_CMPA_LO = 3'h4;
    localparam logic [2:0] OFF_CMPA_HI = 3'h5;
    localparam logic [2:0] OFF_FLAGS   = 3'h6;

    // Control 0 fields
    localparam int unsigned C0_PAUSE   = 7;
    localparam int unsigned C0_CKSEL_LO = 4;
    localparam int unsigned C0_ENABLE  = 3;
    localparam int unsigned C0_PCODE_LO = 0;

    // Control 1 fields
    localparam int unsigned C1_MODE_LO = 6;
    localparam int unsigned C1_PINF_LO = 4;
    localparam int unsigned C1_OUTCTL  = 3;
    localparam int unsigned C1_POL     = 2;
    localparam int unsigned C1_SWAP    = 1;
    localparam int unsigned C1_CCLR    = 0;

    // Flag register fields
    localparam int unsigned FL_MATCH_A = 0;
    localparam int unsigned FL_MATCH_P = 1;

    // Reset values
    localparam logic [7:0] RST_CTRL    = 8'h00;
    localparam logic [9:0] RST_CMPA    = 10'h000;
    localparam logic [9:0] RST_COUNT   = 10'h000;

    // Counter geometry
    localparam logic [10:0] PERIOD_STEP = 11'h080;
    localparam logic [10:0] FULL_COUNT  = 11'h400;

    typedef enum logic [1:0] {
        MODE_COMPARE = 2'b00,
        MODE_CAPTURE = 2'b01,
        MODE_PWM     = 2'b10,
        MODE_TIMER   = 2'b11
    } mode_type;

    typedef enum logic [1:0] {
        PINF_HOLD   = 2'b00,
        PINF_LOW    = 2'b01,
        PINF_HIGH   = 2'b10,
        PINF_TOGGLE = 2'b11
    } pin_function_type;

endpackage : std_timer_pkg

/* rtl/std_timer.sv */
`timescale 1ns/1ps

module std_timer (
    input  wire logic                             clk,
    input  wire logic                             rst_n,
    input  wire logic                             ce,
    input  wire logic [std_timer_pkg::ADDR_W-1:0] addr,
    input  wire logic [std_timer_pkg::DATA_W-1:0] wrData,
    input  wire logic                             wrStrobe,
    input  wire logic                             rdStrobe,
    output logic      [std_timer_pkg::DATA_W-1:0] rdData,
    input  wire logic                             extClockPin,
    output logic                                  timerPin,
    output logic                                  timerPinOe
);
    import std_timer_pkg::*;

    typedef struct packed {
        logic [9:0] count;
        logic [7:0] presc;
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [9:0] cmpA;
        logic       flagA;
        logic       flagP;
        logic       enPrev;
        logic       pinLevel;
        logic       pinOut;
        logic       pinOe;
        logic [7:0] rdData;
        logic       sync1;
        logic       sync2;
        logic       sync3;
        logic       extLevel;
        logic       extPrev;
    } state_type;

    state_type s;
    state_type next_s;

    // Period or duty length for a 3-bit code; code 0 means the full range
    function automatic logic [10:0] periodOf(input logic [2:0] code);
        logic [10:0] len;
        len = PERIOD_STEP * {8'h00, code};
        if (code == 3'h0) begin
            len = FULL_COUNT;
        end
        return len;
    endfunction : periodOf

    // Configuration views
    logic             enable;
    logic             paused;
    logic [2:0]       ckSel;
    logic [2:0]       pCode;
    mode_type         mode;
    pin_function_type pinFn;
    logic             outCtl;
    logic             pol;
    logic             swap;
    logic             cclr;

    assign enable = s.ctrl0[C0_ENABLE];
    assign paused = s.ctrl0[C0_PAUSE];
    assign ckSel  = s.ctrl0[C0_CKSEL_LO +: 3];
    assign pCode  = s.ctrl0[C0_PCODE_LO +: 3];
    assign mode   = mode_type'(s.ctrl1[C1_MODE_LO +: 2]);
    assign pinFn  = pin_function_type'(s.ctrl1[C1_PINF_LO +: 2]);
    assign outCtl = s.ctrl1[C1_OUTCTL];
    assign pol    = s.ctrl1[C1_POL];
    assign swap   = s.ctrl1[C1_SWAP];
    assign cclr   = s.ctrl1[C1_CCLR];

    // Counter clock selection; slow internal sources come from one prescaler
    logic extRise;
    logic extFall;
    logic tick;

    assign extRise = s.extLevel & ~s.extPrev;
    assign extFall = ~s.extLevel & s.extPrev;

    always_comb begin
        case (ckSel)
            3'h0:    tick = (s.presc[1:0] == 2'h3);
            3'h1:    tick = 1'b1;
            3'h2:    tick = (s.presc[3:0] == 4'hf);
            3'h3:    tick = (s.presc[5:0] == 6'h3f);
            3'h6:    tick = extRise;
            3'h7:    tick = extFall;
            default: tick = (s.presc == 8'hff);
        endcase
    end

    // Match detection on the value the counter is about to take
    logic        enRise;
    logic        run;
    logic [10:0] nextCount;
    logic        aHit;
    logic        pHit;
    logic        singlePulse;
    logic [10:0] duty;
    logic        pwmActive;

    assign enRise      = enable & ~s.enPrev;
    assign run         = enable & ~paused & tick & ~enRise;
    assign nextCount   = {1'b0, s.count} + 11'h001;
    assign pHit        = run & (nextCount == periodOf(pCode));
    assign aHit        = run & (s.cmpA != RST_CMPA) & (nextCount == {1'b0, s.cmpA});
    assign singlePulse = (mode == MODE_PWM) & (pinFn == PINF_TOGGLE);
    assign duty        = swap ? periodOf(pCode) : {1'b0, s.cmpA};
    assign pwmActive   = ({1'b0, s.count} < duty);

    // One next-state process for registers, counter, flags and pin
    always_comb begin
        logic       clearCnt;
        logic       setA;
        logic       setP;
        logic       level;
        logic       actLevel;
        next_s = s;
        clearCnt = 1'b0;
        setA = 1'b0;
        setP = 1'b0;
        level = s.pinLevel;
        actLevel = outCtl;

        // Pin input: three stages, level accepted once stages two and three agree
        next_s.presc   = s.presc + 8'h01;
        next_s.sync1   = extClockPin;
        next_s.sync2   = s.sync1;
        next_s.sync3   = s.sync2;
        next_s.extPrev = s.extLevel;
        if (s.sync2 == s.sync3) begin
            next_s.extLevel = s.sync3;
        end

        // Software writes; flags clear by writing one
        if (wrStrobe) begin
            case (addr)
                OFF_CTRL0:   next_s.ctrl0 = wrData;
                OFF_CTRL1:   next_s.ctrl1 = wrData;
                OFF_CMPA_LO: next_s.cmpA[7:0] = wrData;
                OFF_CMPA_HI: next_s.cmpA[9:8] = wrData[1:0];
                OFF_FLAGS: begin
                    next_s.flagA = s.flagA & ~wrData[FL_MATCH_A];
                    next_s.flagP = s.flagP & ~wrData[FL_MATCH_P];
                end
                default: ;
            endcase
        end

        // Counter clearing and flag sources per mode
        case (mode)
            MODE_PWM: begin
                if (singlePulse) begin
                    setA = aHit;
                end else begin
                    clearCnt = swap ? aHit : pHit;
                    setA = aHit;
                    setP = pHit;
                end
            end
            MODE_COMPARE, MODE_TIMER: begin
                if (cclr) begin
                    clearCnt = aHit;
                    setA = aHit;
                end else begin
                    clearCnt = pHit;
                    setA = aHit;
                    setP = pHit;
                end
            end
            default: begin
                clearCnt = pHit;
            end
        endcase

        // Counter: zero on enable rise, hold when stopped or paused
        if (enRise) begin
            next_s.count = RST_COUNT;
        end else if (run && !(singlePulse && aHit)) begin
            next_s.count = clearCnt ? RST_COUNT : nextCount[9:0];
        end

        // Hardware sets win over a same-cycle software clear
        if (setA) begin
            next_s.flagA = 1'b1;
        end
        if (setP) begin
            next_s.flagP = 1'b1;
        end

        // Single pulse: pin edge starts, A match stops by dropping enable
        if (singlePulse) begin
            if (ckSel[0] ? extFall : extRise) begin
                next_s.ctrl0[C0_ENABLE] = 1'b1;
            end
            if (aHit) begin
                next_s.ctrl0[C0_ENABLE] = 1'b0;
            end
        end
        next_s.enPrev = enable;

        // Compare-mode pin level: outCtl on enable rise, then changes on A matches only
        if (enRise) begin
            level = outCtl;
        end else if (aHit) begin
            case (pinFn)
                PINF_LOW:    level = 1'b0;
                PINF_HIGH:   level = 1'b1;
                PINF_TOGGLE: level = ~s.pinLevel;
                default:     level = s.pinLevel;
            endcase
        end
        next_s.pinLevel = level;

        // Pin drive per mode; polarity applied last
        next_s.pinOe = 1'b1;
        case (mode)
            MODE_COMPARE: next_s.pinOut = level ^ pol;
            MODE_PWM: begin
                case (pinFn)
                    PINF_HOLD:   next_s.pinOut = ~actLevel ^ pol;
                    PINF_LOW:    next_s.pinOut = actLevel ^ pol;
                    PINF_HIGH:   next_s.pinOut = (pwmActive ? actLevel : ~actLevel) ^ pol;
                    default:     next_s.pinOut = (enable ? actLevel : ~actLevel) ^ pol;
                endcase
            end
            default: begin
                next_s.pinOut = 1'b0;
                next_s.pinOe  = 1'b0;
            end
        endcase

        // Read data answers in the following cycle only
        next_s.rdData = 8'h00;
        if (rdStrobe) begin
            case (addr)
                OFF_CTRL0:   next_s.rdData = s.ctrl0;
                OFF_CTRL1:   next_s.rdData = s.ctrl1;
                OFF_CNT_LO:  next_s.rdData = s.count[7:0];
                OFF_CNT_HI:  next_s.rdData = {6'h00, s.count[9:8]};
                OFF_CMPA_LO: next_s.rdData = s.cmpA[7:0];
                OFF_CMPA_HI: next_s.rdData = {6'h00, s.cmpA[9:8]};
                OFF_FLAGS:   next_s.rdData = {6'h00, s.flagP, s.flagA};
                default:     next_s.rdData = 8'h00;
            endcase
        end
    end

    // State register; clock enable freezes everything
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign rdData     = s.rdData;
    assign timerPin   = s.pinOut;
    assign timerPinOe = s.pinOe;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_rise_zeroes_cnt: assert property (ce && enRise |=> s.count == RST_COUNT)
        else $error("counter not zeroed on enable rise");

    chk_stop_holds_cnt: assert property (ce && !enable |=> $stable(s.count))
        else $error("stopped counter changed");

    chk_flag_a_sets: assert property (ce && aHit && mode != MODE_CAPTURE |=> s.flagA)
        else $error("compare A flag not set");

    chk_no_p_flag: assert property (ce && (mode == MODE_COMPARE) && cclr && !s.flagP
        && !(wrStrobe && addr == OFF_CTRL1) |=> !s.flagP)
        else $error("P flag raised with clear-select high");

    chk_zero_a_silent: assert property (ce && (mode == MODE_COMPARE) && s.cmpA == RST_CMPA
        && !s.flagA |=> !s.flagA)
        else $error("A flag raised with compare A zero");

    chk_p_match_clears: assert property (ce && pHit && !cclr && mode == MODE_COMPARE
        |=> s.count == RST_COUNT)
        else $error("P match did not clear counter");

    chk_toggle_on_a: assert property (ce && aHit && !enRise && pinFn == PINF_TOGGLE
        |=> s.pinLevel != $past(s.pinLevel))
        else $error("pin did not toggle on A match");

    chk_pin_only_a: assert property (ce && !aHit && !enRise |=> $stable(s.pinLevel))
        else $error("pin level moved without A match");

    chk_timer_no_drive: assert property (ce && mode == MODE_TIMER |=> !timerPinOe)
        else $error("pin driven in timer mode");

    chk_pulse_ends: assert property (ce && singlePulse && aHit |=> !enable ##1 timerPin == (~outCtl ^ pol))
        else $error("single pulse not ended by A match");

    chk_pwm_forced: assert property (ce && mode == MODE_PWM && pinFn == PINF_LOW
        |=> timerPin == ($past(outCtl) ^ $past(pol)))
        else $error("forced active level wrong");

    chk_hi_reads_zero: assert property (ce && rdStrobe && addr == OFF_CNT_HI |=> rdData[7:2] == 6'h00)
        else $error("counter high upper bits not zero");

    chk_pause_holds_cnt: assert property (ce && paused && !enRise |=> $stable(s.count))
        else $error("paused counter changed");

    cov_pwm_period: cover property (ce && mode == MODE_PWM && pinFn == PINF_HIGH && pHit);
    cov_pulse_done: cover property (ce && singlePulse && aHit);
    cov_cmp_toggle: cover property (ce && mode == MODE_COMPARE && pinFn == PINF_TOGGLE && aHit);
    cov_cmp_clear_a: cover property (ce && mode == MODE_COMPARE && cclr && aHit);

endmodule : std_timer

/* testbench/ext_pin_model.sv */
`timescale 1ns/1ps

// Trigger source standing on the external clock pin
module ext_pin_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic fire,
    output logic      extClockPin
);
    logic [3:0] hold;

    // Pulse outlasts the input filter; pin idles low between triggers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold <= 4'h0;
        end else if (fire) begin
            hold <= 4'h8;
        end else if (hold != 4'h0) begin
            hold <= hold - 4'h1;
        end
    end

    assign extClockPin = (hold != 4'h0);
endmodule : ext_pin_model

/* testbench/standard_timer_modes_10bit_test.sv */
`timescale 1ns/1ps

module standard_timer_modes_10bit_test;
    import std_timer_pkg::*;
    logic              clk, rst_n, ce, wrStrobe, rdStrobe, fire, timerPin, timerPinOe, extClockPin;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData, rdData, v, w;
    logic [9:0]        ca;
    logic [2:0]        code;
    logic [1:0]        pf;
    logic              oc, po, sw;
    int                miscompares, n_tests, h, i, per, d;

    std_timer dut (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdData(rdData), .extClockPin(extClockPin), .timerPin(timerPin),
        .timerPinOe(timerPinOe));
    ext_pin_model partner (.clk(clk), .rst_n(rst_n), .fire(fire), .extClockPin(extClockPin));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic end_sim;
        $display("Tests %0d, miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask : check

    task automatic wr(input logic [2:0] a, input logic [7:0] x);
        @(posedge clk);
        addr <= a;
        wrData <= x;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask : wr

    // Read data only stand in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] x);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1 x = rdData;
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Mode bits change only while the counter is off
    task automatic start(input logic [7:0] c1, input logic [7:0] c0, input logic [9:0] a);
        wr(OFF_CTRL0, 8'h00);
        wr(OFF_FLAGS, 8'h03);
        wr(OFF_CMPA_LO, a[7:0]);
        wr(OFF_CMPA_HI, {6'h00, a[9:8]});
        wr(OFF_CTRL1, c1);
        wr(OFF_CTRL0, c0 | 8'h08);
    endtask : start

    function automatic logic [7:0] c1f(logic [1:0] m, logic [1:0] f, logic o, logic p, logic s, logic c);
        return {m, f, o, p, s, c};
    endfunction : c1f

    function automatic logic cmp_pin(logic [1:0] f, logic o);
        return f == 2'b00 ? o : f == 2'b01 ? 1'b0 : f == 2'b10 ? 1'b1 : ~o;
    endfunction : cmp_pin

    // High cycles in one period; duty saturates at the period
    function automatic int pwm_high(logic [1:0] f, logic o, logic p, int dt, int pr);
        int act;
        act = f == 2'b10 ? (dt < pr ? dt : pr) : f == 2'b01 ? pr : 0;
        return (o ^ p) ? act : pr - act;
    endfunction : pwm_high

    // Watchdog, well past the expected run length
    initial begin
        #200000;
        miscompares++;
        end_sim;
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        addr = '0;
        wrData = '0;
        fire = 1'b0;
        ce = 1'b1;
        void'($urandom(46));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 8; i++) begin
            rd(i[2:0], v);
            check(v === 8'h00, "reset value");
        end
        ca = 10'($urandom);
        wr(OFF_CMPA_LO, ca[7:0]);
        wr(OFF_CMPA_HI, {6'h3f, ca[9:8]});
        wr(OFF_CNT_LO, 8'h5a);
        rd(OFF_CMPA_LO, v);
        rd(OFF_CMPA_HI, w);
        check(v === ca[7:0] && w === {6'h00, ca[9:8]}, "compare A readback");
        rd(OFF_CNT_LO, v);
        check(v === 8'h00, "counter read-only");
        // Every pin function on an A match, clear on A
        for (i = 0; i < 4; i++) begin
            oc = 1'($urandom);
            start(c1f(MODE_COMPARE, i[1:0], oc, 1'b0, 1'b0, 1'b1), 8'h10, 10'd40);
            tick(10);
            check(timerPin === oc && timerPinOe === 1'b1, "initial level");
            tick(45);
            check(timerPin === cmp_pin(i[1:0], oc), "match action");
            rd(OFF_FLAGS, v);
            check(v === 8'h01, "only A flag");
        end
        wr(OFF_CTRL0, 8'h10);
        rd(OFF_CNT_LO, v);
        tick(20);
        rd(OFF_CNT_LO, w);
        check(v === w, "count held when off");
        wr(OFF_CTRL0, 8'h18);
        rd(OFF_CNT_LO, v);
        check(v === 8'h00, "count zeroed on start");
        // Clock enable low freezes the running counter; three ticks land around the gap
        rd(OFF_CNT_LO, v);
        @(posedge clk);
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        ce <= 1'b1;
        rd(OFF_CNT_LO, w);
        check(w === v + 8'd3, "count frozen by clock enable");
        wr(OFF_CTRL0, 8'h98);
        rd(OFF_CNT_LO, v);
        tick(20);
        rd(OFF_CNT_LO, w);
        check(v === w, "count held when paused");
        start(c1f(MODE_COMPARE, PINF_TOGGLE, 1'b0, 1'b0, 1'b0, 1'b0), 8'h11, 10'd40);
        tick(150);
        rd(OFF_FLAGS, v);
        check(v === 8'h03, "both flags");
        rd(OFF_CNT_HI, v);
        rd(OFF_CNT_LO, w);
        check(v === 8'h00 && w < 8'd40, "clear on P");
        // Compare A of zero: overflow, no A flag, pin untouched by P
        start(c1f(MODE_COMPARE, PINF_TOGGLE, 1'b0, 1'b0, 1'b0, 1'b0), 8'h10, 10'd0);
        tick(1100);
        rd(OFF_FLAGS, v);
        check(v === 8'h02 && timerPin === 1'b0, "overflow without A");
        start(c1f(MODE_TIMER, PINF_TOGGLE, 1'b1, 1'b0, 1'b0, 1'b1), 8'h10, 10'd20);
        tick(30);
        rd(OFF_FLAGS, v);
        check(v === 8'h01 && timerPinOe === 1'b0, "timer mode");
        // PWM cases: plain, saturated, period code 2, swapped, forced inactive and active
        for (i = 0; i < 6; i++) begin
            oc = 1'($urandom);
            po = 1'($urandom);
            sw = (i == 3);
            code = (i == 2) ? 3'd2 : 3'd1;
            pf = i < 4 ? PINF_HIGH : i == 4 ? PINF_HOLD : PINF_LOW;
            ca = i == 1 ? 10'd200 : i == 3 ? 10'd300 : 10'(1 + $urandom % (code * 128 - 1));
            per = i == 3 ? 300 : code * 128;
            d = i == 3 ? 128 : ca;
            start(c1f(MODE_PWM, pf, oc, po, sw, 1'b1), {5'b00010, code}, ca);
            tick(320);
            h = 0;
            repeat (per) begin
                tick(1);
                if (timerPin === 1'b1) h++;
            end
            check(h == pwm_high(pf, oc, po, d, per), "pwm duty");
            rd(OFF_FLAGS, v);
            check(v === (i == 1 ? 8'h02 : 8'h03), "pwm flags");
        end
        // Single pulse: end on A match, on software stop, trigger from pin
        start(c1f(MODE_PWM, PINF_TOGGLE, 1'b1, 1'b0, 1'b0, 1'b0), 8'h10, 10'd50);
        tick(10);
        check(timerPin === 1'b1, "pulse leading edge");
        tick(60);
        rd(OFF_CTRL0, v);
        check(timerPin === 1'b0 && v[C0_ENABLE] === 1'b0, "pulse end on A");
        wr(OFF_CTRL0, 8'h18);
        tick(10);
        check(timerPin === 1'b1, "pulse restarted");
        wr(OFF_CTRL0, 8'h10);
        tick(3);
        check(timerPin === 1'b0, "pulse end by software");
        wr(OFF_CTRL0, 8'h60);
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        tick(15);
        rd(OFF_CTRL0, v);
        check(timerPin === 1'b1 && v[C0_ENABLE] === 1'b1, "pin trigger");
        end_sim;
    end
endmodule : standard_timer_modes_10bit_test
